// ### common/clock_manager_map.svh
// Constants of the clock manager output and status block.
// Assumes the includer supplies widths through these macros only.
`ifndef CLOCK_MANAGER_MAP_SVH
`define CLOCK_MANAGER_MAP_SVH

// Period counters, in system clock cycles
`define CM_PW 12
`define CM_MIN_PER 12'h004
// Reference cycles of steady period before lock
`define CM_LOCK_REFS 2048
// Reference edges with no feedback edge
`define CM_FB_STOP_REFS 8'h02
`define CM_FB_LOSS_REFS 8'h40
// Quiet reference periods before synth output counts as dead
`define CM_FX_DEAD_REFS 9'h102
// Phase shift range and step latency in shift clocks
`define CM_SHIFT_LIMIT 10'sh0FF
`define CM_STEP_PSCLKS 4'h4
// Status word bit positions
`define CM_ST_OVF 0
`define CM_ST_REF 1
`define CM_ST_FX 2
`define CM_ST_FB 3
// Output clock bit positions
`define CM_CO_ZERO 0
`define CM_CO_QTR 1
`define CM_CO_HALF 2
`define CM_CO_TQ 3
`define CM_CO_DBL 4
`define CM_CO_DBLN 5
`define CM_CO_DIV 6
`define CM_CO_FX 7
`define CM_CO_FXN 8

`endif

// ### common/clock_manager_pkg.sv
// Types of the clock manager output and status block.
// Assumes clock_manager_map.svh is on the include path.
`include "clock_manager_map.svh"

package clock_manager_pkg;

    typedef enum logic [1:0] {LK_WAIT, LK_ACQ, LK_LOCKED, LK_LOST} lock_e;

    typedef struct packed {
        lock_e lk;
        logic ref_p;
        logic fb_p;
        logic ps_p;
        logic halve;
        logic [`CM_PW-1:0] since_ref;
        logic [`CM_PW-1:0] per;
        logic [`CM_PW-1:0] ph;
        logic [`CM_PW-1:0] same;
        logic [7:0] fb_refs;
        logic ref_stop;
        logic fb_stop;
        logic [5:0] dv;
        logic [5:0] dcnt;
        logic [17:0] acc;
        logic [`CM_PW-1:0] fx_sys;
        logic [8:0] fx_refs;
        logic fx_dead;
        logic fx_prev;
        logic signed [9:0] off;
        logic ps_busy;
        logic [3:0] ps_wait;
        logic ovf;
        logic done;
        logic [8:0] clk_o;
        logic [15:0] stat;
        logic rdy;
    } state_s;

endpackage

// ### logic/clock_manager.sv
// Clock manager output side: derived clocks, lock, shift done, status.
// Assumes all inputs are synchronous to clk_sys_in, which oversamples
// the reference, feedback and shift clocks by at least four.
//
// Operation
// - Nine output clocks, fixed phase to reference when feedback is used.
// - Without feedback, outputs free-run but keep relative phase.
// - Zero-phase output runs at reference rate, halved when option set.
// - Three more 1x outputs delayed by quarter, half, three quarters.
// - Doubled output twice zero-phase rate, aligned, even duty.
// - Before lock, doubled output is a 1x clock, quarter high.
// - Inverted doubled output is the complement of doubled output, a half period shift once locked.
// - Divided output aligned to zero-phase, twice reference over divide value.
// - Synth output runs at reference times multiplier over divisor.
// - Synth rising edges coincide with zero-phase every divisor cycles.
// - Inverted synth output is synth output shifted half period.
// - After reset, sample thousands of reference cycles, then raise lock.
// - With hold_config_until_lock option, hold configuration done until lock.
// - Shift done pulses one shift clock period when a step completes.
// - Status bit 0 flags a shift beyond the allowed range.
// - Status bit 1 flags stopped reference within nine cycles.
// - Status bit 2 flags synth stop after 257-260 cycles, sticky.
// - All status bits stay low while lock is low.
// - Reconfiguration ready answers each reconfiguration request.
// - With request low, data output presents the status bits.
// - Restart forces lock, status and clocks low; release relocks.
`timescale 1ns/1ns
`default_nettype none
`include "clock_manager_map.svh"

module clock_manager
    import clock_manager_pkg::*;
#(
    parameter int LOCK_REF_CYCLES = `CM_LOCK_REFS
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic restart_in,
    input wire logic reference_input_clock_in,
    input wire logic feedback_input_clock_in,
    input wire logic feedback_connected_in,
    input wire logic input_halving_option_in,
    input wire logic [5:0] divider_setting_in,
    input wire logic [5:0] synth_multiplier_in,
    input wire logic [5:0] synth_divisor_in,
    input wire logic hold_config_until_lock_in,
    input wire logic shift_step_clock_in,
    input wire logic shift_request_in,
    input wire logic shift_increment_in,
    input wire logic reconfig_request_in,
    output logic zero_phase_output_out,
    output logic quarter_phase_output_out,
    output logic half_phase_output_out,
    output logic three_quarter_phase_output_out,
    output logic doubled_output_out,
    output logic doubled_inverted_output_out,
    output logic divided_output_out,
    output logic synthesized_output_out,
    output logic synthesized_inverted_output_out,
    output logic locked_out,
    output logic shift_done_pulse_out,
    output logic [15:0] clock_monitor_status_word_out,
    output logic reconfig_ready_out,
    output logic config_hold_out
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic rise(input logic p, input logic c);
        rise = c && !p;
    endfunction

    function automatic logic [`CM_PW-1:0] sat_inc(
        input logic [`CM_PW-1:0] v);
        sat_inc = (&v) ? v : v + 1'b1;
    endfunction

    state_s q, d;
    logic rr, re, fr, pr, valid, close, locked_n, coin, fxv;
    logic [`CM_PW-1:0] new_per, h, qt, tq;
    logic [17:0] modv, acc_n;
    logic signed [9:0] nx;
    logic [15:0] stat;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d = q;
        rr = rise(q.ref_p, reference_input_clock_in);
        fr = rise(q.fb_p, feedback_input_clock_in);
        pr = rise(q.ps_p, shift_step_clock_in);
        d.ref_p = reference_input_clock_in;
        d.fb_p = feedback_input_clock_in;
        d.ps_p = shift_step_clock_in;
        // Toggle stage halves the effective reference
        d.halve = q.halve ^ rr;
        re = rr && (!input_halving_option_in || !q.halve);
        valid = q.per >= `CM_MIN_PER;
        new_per = sat_inc(q.since_ref);
        close = (new_per <= q.per + 1'b1) && (q.per <= new_per + 1'b1);

        // Period measure and reference stop
        d.since_ref = re ? '0 : sat_inc(q.since_ref);
        if (re) begin
            d.per = new_per;
        end
        d.ref_stop = !re && valid &&
            (q.ref_stop || q.since_ref >= q.per);

        // Feedback watch in reference edges
        if (fr) begin
            d.fb_refs = '0;
        end else if (re && !(&q.fb_refs)) begin
            d.fb_refs = q.fb_refs + 1'b1;
        end
        d.fb_stop = feedback_connected_in && !fr &&
            (q.fb_stop || d.fb_refs >= `CM_FB_STOP_REFS);

        // Lock sequence
        unique case (q.lk)
            LK_WAIT: begin
                d.same = '0;
                if (re) begin
                    d.lk = LK_ACQ;
                end
            end
            LK_ACQ: begin
                if (re) begin
                    if (!close || new_per < `CM_MIN_PER) begin
                        d.same = '0;
                    end else if (q.same >= `CM_PW'(LOCK_REF_CYCLES - 1))
                    begin
                        d.lk = LK_LOCKED;
                    end else begin
                        d.same = q.same + 1'b1;
                    end
                end
            end
            LK_LOCKED: begin
                if (feedback_connected_in &&
                    q.fb_refs >= `CM_FB_LOSS_REFS) begin
                    d.lk = LK_LOST;
                end
            end
            LK_LOST: begin
                d.lk = LK_LOST;
            end
        endcase
        locked_n = d.lk == LK_LOCKED;

        // Phase counter; realigned to the reference only with feedback
        if (q.ref_stop) begin
            d.ph = q.ph;
        end else if ((re && feedback_connected_in) ||
            q.ph >= q.per - 1'b1) begin
            d.ph = '0;
        end else begin
            d.ph = q.ph + 1'b1;
        end
        h = q.per >> 1;
        qt = q.per >> 2;
        tq = h + qt;
        d.clk_o = '0;
        if (valid) begin
            d.clk_o[`CM_CO_ZERO] = d.ph < h;
            d.clk_o[`CM_CO_QTR] = d.ph >= qt && d.ph < tq;
            d.clk_o[`CM_CO_HALF] = d.ph >= h;
            d.clk_o[`CM_CO_TQ] = !(d.ph >= qt && d.ph < tq);
            if (locked_n) begin
                d.clk_o[`CM_CO_DBL] = d.ph < qt ||
                    (d.ph >= h && d.ph < tq);
            end else begin
                d.clk_o[`CM_CO_DBL] = d.ph < qt;
            end
            d.clk_o[`CM_CO_DBLN] = !d.clk_o[`CM_CO_DBL];
        end

        // Divider counts half periods of the effective reference
        if (d.ph != q.ph && (d.ph == '0 || d.ph == h)) begin
            d.dv = (q.dv >= divider_setting_in - 1'b1) ? '0 :
                q.dv + 1'b1;
        end
        if (valid) begin
            d.clk_o[`CM_CO_DIV] = d.dv < (divider_setting_in >> 1);
        end

        // Synthesizer: accumulator realigned every divisor cycles
        if (re) begin
            d.dcnt = (q.dcnt >= synth_divisor_in - 1'b1) ? '0 :
                q.dcnt + 1'b1;
        end
        coin = re && d.dcnt == '0;
        modv = 18'(synth_divisor_in) * 18'(q.per);
        acc_n = q.acc + 18'(synth_multiplier_in);
        if (acc_n >= modv) begin
            acc_n = acc_n - modv;
        end
        if (coin) begin
            d.acc = '0;
            // Divider realigned only while locking, keeps its own rate
            if (!locked_n) begin
                d.dv = '0;
            end
        end else if (!q.ref_stop && !q.fx_dead) begin
            d.acc = acc_n;
        end
        fxv = valid && !q.fx_dead && d.acc < (modv >> 1);
        d.clk_o[`CM_CO_FX] = fxv;
        d.clk_o[`CM_CO_FXN] = valid && !q.fx_dead && !fxv;

        // Synth stop watch counts quiet reference periods
        d.fx_prev = fxv;
        if (fxv != q.fx_prev) begin
            d.fx_sys = '0;
            d.fx_refs = '0;
        end else if (q.fx_sys >= q.per - 1'b1) begin
            d.fx_sys = '0;
            if (!(&q.fx_refs)) begin
                d.fx_refs = q.fx_refs + 1'b1;
            end
        end else begin
            d.fx_sys = q.fx_sys + 1'b1;
        end
        if (locked_n && q.fx_refs >= `CM_FX_DEAD_REFS) begin
            d.fx_dead = 1'b1;
        end

        // Phase shift steps on shift clock edges
        nx = q.off + (shift_increment_in ? 10'sh001 : -10'sh001);
        if (pr) begin
            d.done = 1'b0;
            if (q.ps_busy) begin
                if (q.ps_wait == '0) begin
                    d.ps_busy = 1'b0;
                    d.done = 1'b1;
                end else begin
                    d.ps_wait = q.ps_wait - 1'b1;
                end
            end else if (shift_request_in) begin
                if (nx > `CM_SHIFT_LIMIT || nx < -`CM_SHIFT_LIMIT) begin
                    d.ovf = 1'b1;
                end else begin
                    d.off = nx;
                    d.ovf = 1'b0;
                end
                d.ps_busy = 1'b1;
                d.ps_wait = `CM_STEP_PSCLKS - 1'b1;
            end
        end

        // Status word, masked while unlocked
        stat = '0;
        if (locked_n) begin
            stat[`CM_ST_OVF] = d.ovf;
            stat[`CM_ST_REF] = d.ref_stop;
            stat[`CM_ST_FX] = d.fx_dead;
            stat[`CM_ST_FB] = d.fb_stop;
        end
        d.stat = reconfig_request_in ? '0 : stat;
        d.rdy = reconfig_request_in;

        if (restart_in) begin
            d = '0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign zero_phase_output_out = q.clk_o[`CM_CO_ZERO];
    assign quarter_phase_output_out = q.clk_o[`CM_CO_QTR];
    assign half_phase_output_out = q.clk_o[`CM_CO_HALF];
    assign three_quarter_phase_output_out = q.clk_o[`CM_CO_TQ];
    assign doubled_output_out = q.clk_o[`CM_CO_DBL];
    assign doubled_inverted_output_out = q.clk_o[`CM_CO_DBLN];
    assign divided_output_out = q.clk_o[`CM_CO_DIV];
    assign synthesized_output_out = q.clk_o[`CM_CO_FX];
    assign synthesized_inverted_output_out = q.clk_o[`CM_CO_FXN];
    assign locked_out = q.lk == LK_LOCKED;
    assign shift_done_pulse_out = q.done;
    assign clock_monitor_status_word_out = q.stat;
    assign reconfig_ready_out = q.rdy;
    assign config_hold_out = hold_config_until_lock_in &&
        !locked_out;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!resetn_in);

    status_mask_a: assert property (
        !locked_out |-> clock_monitor_status_word_out == '0)
        else $error("status visible while unlocked");
    status_high_a: assert property (
        clock_monitor_status_word_out[15:4] == '0)
        else $error("unassigned status bits set");
    done_rise_a: assert property (
        $rose(shift_done_pulse_out) |-> $past(pr) && $past(q.ps_busy))
        else $error("shift done rose off a shift clock edge");
    done_fall_a: assert property (
        $fell(shift_done_pulse_out) |-> $past(pr) || $past(restart_in))
        else $error("shift done fell early");
    ready_answer_a: assert property (
        reconfig_request_in && !restart_in |=> reconfig_ready_out)
        else $error("request not answered");
    fx_sticky_a: assert property (
        q.fx_dead && !restart_in |=> q.fx_dead && !synthesized_output_out)
        else $error("synth output resumed after stop");
    restart_low_a: assert property (
        restart_in |=> !locked_out && q.clk_o == '0 &&
            clock_monitor_status_word_out == '0)
        else $error("restart left outputs high");
    lock_count_a: assert property (
        $rose(locked_out) |->
            $past(q.same) == `CM_PW'(LOCK_REF_CYCLES - 1))
        else $error("lock raised before steady period count");
    ref_stop_a: assert property (
        $rose(q.ref_stop) |-> $past(q.since_ref) >= $past(q.per))
        else $error("reference stop flagged too early");
    inverse_a: assert property (
        locked_out |-> doubled_inverted_output_out != doubled_output_out &&
            half_phase_output_out != zero_phase_output_out)
        else $error("inverse outputs not complementary");
    hold_cfg_a: assert property (
        hold_config_until_lock_in && q.lk != LK_LOCKED |-> config_hold_out)
        else $error("configuration released before lock");

    lock_c: cover property ($rose(locked_out));
    done_c: cover property ($rose(shift_done_pulse_out));
    fx_dead_c: cover property ($rose(q.fx_dead));
    ref_stop_c: cover property (locked_out && $rose(q.ref_stop));

endmodule

`default_nettype wire

// ### dv/fabric_model.sv
// Fabric side model: reference, feedback and shift clock stimulus.
// Assumes clk_in is the bench system clock; all changes at its rise.
`timescale 1ns/1ns
`default_nettype none
module fabric_model (
    input wire logic clk_in,
    input wire logic ref_run_in,
    input wire logic fb_use_in,
    input wire logic zero_in,
    input wire logic go_in,
    input wire logic inc_in,
    output logic ref_out,
    output logic fb_out,
    output logic ps_clk_out,
    output logic ps_req_out,
    output logic ps_inc_out
);
    //************************************************
    // Clock and step request generation
    //************************************************
    logic [1:0] rc_q = 2'h0;
    logic [1:0] pc_q = 2'h0;
    logic pend_q = 1'b0;
    initial begin
        ref_out = 1'b0;
        ps_clk_out = 1'b0;
        ps_req_out = 1'b0;
        ps_inc_out = 1'b0;
    end
    // Stopped feedback rests low
    assign fb_out = fb_use_in ? zero_in : 1'b0;
    always @(posedge clk_in) begin
        pc_q <= pc_q + 2'h1;
        if (go_in) begin
            pend_q <= 1'b1;
        end
        if (pc_q == 2'h3) begin
            ps_clk_out <= ~ps_clk_out;
            // Request spans fall to fall: one shift clock period
            if (ps_clk_out) begin
                ps_req_out <= pend_q;
                ps_inc_out <= inc_in;
                pend_q <= go_in;
            end
        end
        if (ref_run_in) begin
            rc_q <= rc_q + 2'h1;
            if (rc_q == 2'h3) begin
                ref_out <= ~ref_out;
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench of the clock manager block.
// Assumes the design, package and fabric_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "clock_manager_map.svh"
`define CHK(a, e) begin \
    n_compared++; \
    if ((a) !== (e)) begin \
        fails++; \
        $display("CHECK FAILED %0t %0h %0h", $time, a, e); \
    end \
end
module tb_top;
    //************************************************
    // Stimulus, instances and scenarios
    //************************************************
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic restart = 1'b0;
    logic halve = 1'b0;
    logic hold = 1'b1;
    logic fb_conn = 1'b1;
    logic [5:0] dv_set = 6'h04;
    logic [5:0] m_set = 6'h03;
    logic [5:0] d_set = 6'h02;
    logic ref_run = 1'b1;
    logic fb_use = 1'b1;
    logic go = 1'b0;
    logic inc = 1'b0;
    logic req = 1'b0;
    wire logic ref_clk, fb_clk, ps_clk, ps_req, ps_inc;
    wire logic [8:0] co;
    wire logic locked, done, rdy, chold;
    wire logic [15:0] word;
    int fails = 0;
    int n_compared = 0;
    int rs[9];
    int c[6];
    clock_manager #(.LOCK_REF_CYCLES(32)) u_clock_manager (
        .clk_sys_in(clk), .resetn_in(resetn), .restart_in(restart),
        .reference_input_clock_in(ref_clk), .feedback_input_clock_in(fb_clk),
        .feedback_connected_in(fb_conn), .input_halving_option_in(halve),
        .divider_setting_in(dv_set), .synth_multiplier_in(m_set),
        .synth_divisor_in(d_set), .hold_config_until_lock_in(hold),
        .shift_step_clock_in(ps_clk), .shift_request_in(ps_req),
        .shift_increment_in(ps_inc), .reconfig_request_in(req),
        .zero_phase_output_out(co[0]), .quarter_phase_output_out(co[1]),
        .half_phase_output_out(co[2]),
        .three_quarter_phase_output_out(co[3]),
        .doubled_output_out(co[4]), .doubled_inverted_output_out(co[5]),
        .divided_output_out(co[6]), .synthesized_output_out(co[7]),
        .synthesized_inverted_output_out(co[8]), .locked_out(locked),
        .shift_done_pulse_out(done), .clock_monitor_status_word_out(word),
        .reconfig_ready_out(rdy), .config_hold_out(chold));
    fabric_model u_fabric_model (
        .clk_in(clk), .ref_run_in(ref_run), .fb_use_in(fb_use),
        .zero_in(co[0]), .go_in(go), .inc_in(inc), .ref_out(ref_clk),
        .fb_out(fb_clk), .ps_clk_out(ps_clk), .ps_req_out(ps_req),
        .ps_inc_out(ps_inc));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Edge counts and phase coincidences over n cycles, quarter = q
    task automatic measure(input int n, input int q);
        logic [8:0] pv;
        logic [8:0] r;
        logic [15:0] zs;
        pv = co;
        zs = '0;
        foreach (rs[i]) rs[i] = 0;
        foreach (c[i]) c[i] = 0;
        for (int k = -16; k < n; k++) begin
            @(posedge clk);
            zs = {zs[14:0], co[0]};
            r = co & ~pv;
            if (k >= 0) begin
                foreach (rs[i]) rs[i] += int'(r[i]);
                c[0] += int'(co[4]);
                c[1] += int'(co[4] == co[5]);
                c[2] += int'(r[1] & zs[q] & ~zs[q+1])
                    + int'(r[2] & zs[2*q] & ~zs[2*q+1])
                    + int'(r[3] & zs[3*q] & ~zs[3*q+1]);
                c[3] += int'(r[4] & r[0]);
                c[4] += int'(r[6] & r[0]);
                c[5] += int'(r[7] & r[0]);
            end
            pv = co;
        end
    endtask
    task automatic wait_lock(input int lim);
        int k;
        k = 0;
        while (locked !== 1'b1 && k < lim) begin
            @(posedge clk);
            k++;
        end
        `CHK(locked, 1'b1);
        `CHK(chold, 1'b0);
    endtask
    task automatic t_restart(input logic hv, input logic [5:0] dv);
        @(posedge clk) begin
            restart <= 1'b1;
            halve <= hv;
            dv_set <= dv;
        end
        cyc(2);
        `CHK({locked, word, co}, 26'h0);
        @(posedge clk) restart <= 1'b0;
        wait_lock(1500);
    endtask
    task automatic t_prelock();
        cyc(80);
        measure(64, 2);
        `CHK(rs[4], 8);
        `CHK(c[0], 16);
        `CHK({locked, chold, word}, 18'h10000);
        wait_lock(600);
    endtask
    task automatic t_clocks(input int per);
        int n;
        int z;
        n = 768;
        z = n / per;
        measure(n, per / 4);
        `CHK(rs[0], z);
        `CHK(c[2], 3 * z);
        `CHK(rs[4], 2 * z);
        `CHK(c[3], z);
        `CHK(c[0], n / 2);
        `CHK(c[1], 0);
        `CHK(c[4], z * 2 / int'(dv_set));
        `CHK(rs[7], z * int'(m_set) / int'(d_set));
        `CHK(c[5], z / int'(d_set));
        `CHK(rs[8], rs[7]);
    endtask
    task automatic step(input logic up);
        int k;
        int w;
        k = 0;
        w = 0;
        @(posedge clk) begin
            go <= 1'b1;
            inc <= up;
        end
        @(posedge clk) go <= 1'b0;
        while (done !== 1'b1 && k < 80) begin
            @(posedge clk);
            k++;
        end
        while (done === 1'b1 && w < 20) begin
            @(posedge clk);
            w++;
        end
        `CHK(w, 8);
    endtask
    task automatic t_shift();
        repeat (255) step(1'b0);
        `CHK(word[`CM_ST_OVF], 1'b0);
        step(1'b0);
        `CHK(word[`CM_ST_OVF], 1'b1);
        @(posedge clk) req <= 1'b1;
        @(posedge clk) req <= 1'b0;
        @(posedge clk);
        `CHK({rdy, word}, 17'h10000);
        @(posedge clk);
        `CHK({rdy, word}, 17'h00001);
        step(1'b1);
        `CHK(word, 16'h0000);
    endtask
    task automatic t_ref_stop();
        @(posedge clk) ref_run <= 1'b0;
        cyc(72);
        `CHK(word[`CM_ST_REF], 1'b1);
        cyc(2048 - 72);
        `CHK(word[`CM_ST_FX], 1'b0);
        cyc(40);
        `CHK(word[`CM_ST_FX], 1'b1);
        @(posedge clk) ref_run <= 1'b1;
        cyc(72);
        `CHK(word[2:1], 2'b10);
        measure(64, 2);
        `CHK(rs[7], 0);
    endtask
    task automatic t_fb_stop();
        @(posedge clk) fb_use <= 1'b0;
        cyc(48);
        `CHK(word[`CM_ST_FB], 1'b1);
        @(posedge clk) fb_use <= 1'b1;
        cyc(48);
        `CHK({locked, word[`CM_ST_FB]}, 2'b10);
        @(posedge clk) fb_use <= 1'b0;
        cyc(528);
        `CHK({locked, word}, 17'h0);
        @(posedge clk) fb_use <= 1'b1;
    endtask
    initial begin
        cyc(20);
        `CHK({locked, word, co, chold}, 27'h1);
        @(posedge clk) resetn <= 1'b1;
        t_prelock();
        // Full clock set judged once locked; t_prelock checks only the doubled output before lock
        t_clocks(8);
        t_shift();
        t_ref_stop();
        t_restart(1'b0, 6'h04);
        t_fb_stop();
        t_restart(1'b1, 6'h06);
        t_clocks(16);
        wrap_up();
    end
    initial begin
        cyc(60000);
        fails++;
        wrap_up();
    end
endmodule
`default_nettype wire
